// [src/fpc_ctrl.sv]
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "fpc_defines.svh"
// What this block does
// - Freeze overlay: three unlock writes ending 50; A0 then 0 clears lock.
// - Dynamic overlay entered by unlock ending E0; A0 then 0 sets, 1 clears.
// - Command cycles are writes except array, status and overlay reads.
// - Host issues reset to return to array reads from an overlay.
// - After any entry host issues an exit before expecting read state.
module fpc_ctrl #(
	parameter int AW = 26
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Flash pins
	output logic [AW-1:0]    flash_addr,
	output logic [15:0]      flash_dq_out,
	output logic             flash_dq_oe,
	input  wire logic [15:0] flash_dq_in,
	output logic             flash_ce_n,
	output logic             flash_oe_n,
	output logic             flash_we_n
);

	fpc_pkg::fpc_state_s s_r;
	fpc_pkg::fpc_state_s s_nxt;
	logic [15:0]         dq_meta_r;
	logic [15:0]         dq_sync_r;
	fpc_pkg::fpc_cycle_s cyc;

	// Flash data pins cross in from an asynchronous device
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dq_meta_r <= 16'h0000;
			dq_sync_r <= 16'h0000;
		end else begin
			dq_meta_r <= flash_dq_in;
			dq_sync_r <= dq_meta_r;
		end
	end

	// Cycle count of each operation
	function automatic logic [2:0] op_len(input fpc_pkg::fpc_op_e op);
		unique case (op)
			fpc_pkg::FPC_OP_FREEZE_ENTER, fpc_pkg::FPC_OP_DYN_ENTER,
			fpc_pkg::FPC_OP_ECC_ENTER:   op_len = 3'h3;
			fpc_pkg::FPC_OP_FREEZE_CLEAR, fpc_pkg::FPC_OP_DYN_SET,
			fpc_pkg::FPC_OP_DYN_CLEAR, fpc_pkg::FPC_OP_SET_EXIT: op_len = 3'h2;
			default:                     op_len = 3'h1;
		endcase
	endfunction

	// Address and data of one step of an operation
	function automatic fpc_pkg::fpc_cycle_s op_cycle(input fpc_pkg::fpc_op_e op,
			input logic [2:0] step, input logic [25:0] a);
		logic [25:0] sect;
		logic [15:0] third;
		sect = a & ~((26'h1 << `FPC_SECTOR_LSB) - 26'h1);
		op_cycle = '{is_read: 1'b0, addr: 26'h0, data: 16'h0000};
		third = `FPC_CODE_FREEZE;
		unique case (op)
			fpc_pkg::FPC_OP_FREEZE_ENTER, fpc_pkg::FPC_OP_DYN_ENTER,
			fpc_pkg::FPC_OP_ECC_ENTER: begin
				if (op == fpc_pkg::FPC_OP_DYN_ENTER)
					third = `FPC_CODE_DYN;
				else if (op == fpc_pkg::FPC_OP_ECC_ENTER)
					third = `FPC_CODE_ECC;
				unique case (step)
					3'h0: op_cycle = '{1'b0, {10'h0, `FPC_UNLOCK1_ADDR}, `FPC_UNLOCK1_DATA};
					3'h1: op_cycle = '{1'b0, {10'h0, `FPC_UNLOCK2_ADDR}, `FPC_UNLOCK2_DATA};
					default: op_cycle = '{1'b0, {10'h0, `FPC_UNLOCK1_ADDR}, third};
				endcase
			end
			fpc_pkg::FPC_OP_FREEZE_CLEAR:
				op_cycle = '{1'b0, 26'h0, (step == 3'h0) ? `FPC_CODE_PROG : `FPC_CODE_ZERO};
			fpc_pkg::FPC_OP_DYN_SET, fpc_pkg::FPC_OP_DYN_CLEAR: begin
				if (step == 3'h0)
					op_cycle = '{1'b0, 26'h0, `FPC_CODE_PROG};
				else
					op_cycle = '{1'b0, sect, (op == fpc_pkg::FPC_OP_DYN_SET) ?
						`FPC_CODE_ZERO : `FPC_CODE_ONE};
			end
			fpc_pkg::FPC_OP_FREEZE_READ: op_cycle = '{1'b1, 26'h0, 16'h0000};
			fpc_pkg::FPC_OP_DYN_READ:    op_cycle = '{1'b1, sect, 16'h0000};
			fpc_pkg::FPC_OP_ARRAY_READ, fpc_pkg::FPC_OP_ECC_READ:
				op_cycle = '{1'b1, a, 16'h0000};
			fpc_pkg::FPC_OP_SET_EXIT:
				op_cycle = '{1'b0, 26'h0, (step == 3'h0) ? `FPC_CODE_EXIT1 : `FPC_CODE_ZERO};
			fpc_pkg::FPC_OP_RESET_EXIT: op_cycle = '{1'b0, 26'h0, `FPC_CODE_RESET};
			default: op_cycle = '{1'b0, 26'h0, 16'h0000};
		endcase
	endfunction

	// Mode after an operation ends
	function automatic fpc_pkg::fpc_mode_e op_mode(input fpc_pkg::fpc_op_e op,
			input fpc_pkg::fpc_mode_e m);
		unique case (op)
			fpc_pkg::FPC_OP_FREEZE_ENTER: op_mode = fpc_pkg::FPC_MODE_FREEZE;
			fpc_pkg::FPC_OP_DYN_ENTER:    op_mode = fpc_pkg::FPC_MODE_DYN;
			fpc_pkg::FPC_OP_ECC_ENTER:    op_mode = fpc_pkg::FPC_MODE_ECC;
			// Reset or exit returns to array
			fpc_pkg::FPC_OP_SET_EXIT, fpc_pkg::FPC_OP_RESET_EXIT:
				op_mode = fpc_pkg::FPC_MODE_ARRAY;
			default:                      op_mode = m;
		endcase
	endfunction

	// Operation legal in the current mode
	function automatic logic op_ok(input fpc_pkg::fpc_op_e op, input fpc_pkg::fpc_mode_e m);
		unique case (op)
			fpc_pkg::FPC_OP_FREEZE_ENTER, fpc_pkg::FPC_OP_DYN_ENTER,
			fpc_pkg::FPC_OP_ECC_ENTER, fpc_pkg::FPC_OP_ARRAY_READ:
				op_ok = (m == fpc_pkg::FPC_MODE_ARRAY);
			fpc_pkg::FPC_OP_FREEZE_CLEAR, fpc_pkg::FPC_OP_FREEZE_READ:
				op_ok = (m == fpc_pkg::FPC_MODE_FREEZE);
			fpc_pkg::FPC_OP_DYN_SET, fpc_pkg::FPC_OP_DYN_CLEAR, fpc_pkg::FPC_OP_DYN_READ:
				op_ok = (m == fpc_pkg::FPC_MODE_DYN);
			fpc_pkg::FPC_OP_ECC_READ:  op_ok = (m == fpc_pkg::FPC_MODE_ECC);
			// Exit only from an overlay; ECC leaves by F0 only
			fpc_pkg::FPC_OP_SET_EXIT:
				op_ok = (m == fpc_pkg::FPC_MODE_FREEZE) || (m == fpc_pkg::FPC_MODE_DYN);
			fpc_pkg::FPC_OP_RESET_EXIT: op_ok = 1'b1;
			default:                   op_ok = 1'b0;
		endcase
	endfunction

	assign cyc = op_cycle(s_r.op, s_r.step, s_r.addr);

	// Bus slave, register file and flash sequencer
	always_comb begin
		logic [3:0] opv;
		s_nxt = s_r;
		opv = 4'h0;
		s_nxt.hready = 1'b1;
		s_nxt.done = s_r.done;
		// Data phase of a captured transfer
		if (s_r.dp_valid) begin
			if (s_r.dp_write) begin
				unique case (s_r.dp_addr)
					`FPC_OFF_ADDR: s_nxt.addr = hwdata[25:0];
					`FPC_OFF_CMD: begin
						opv = hwdata[`FPC_CMD_OP_LSB +: `FPC_CMD_OP_W];
						// No password ops; busy, unknown, misplaced refused
						if (s_r.busy || opv > 4'hb ||
								!op_ok(fpc_pkg::fpc_op_e'(opv), s_r.mode)) begin
							s_nxt.err = 1'b1;
						end else begin
							s_nxt.op = fpc_pkg::fpc_op_e'(opv);
							s_nxt.nsteps = op_len(fpc_pkg::fpc_op_e'(opv));
							s_nxt.step = 3'h0;
							s_nxt.busy = 1'b1;
							s_nxt.done = 1'b0;
							s_nxt.err = 1'b0;
							s_nxt.phase = fpc_pkg::FPC_PH_SETUP;
							s_nxt.cnt = 4'(`FPC_N_SETUP);
						end
					end
					`FPC_OFF_STATUS: begin
						// Write one to clear; a finishing op wins below
						if (hwdata[`FPC_ST_DONE])
							s_nxt.done = 1'b0;
						if (hwdata[`FPC_ST_ERR])
							s_nxt.err = 1'b0;
					end
					default: ;
				endcase
			end
		end
		// Address phase: capture, readback prepared for next cycle
		s_nxt.dp_valid = hsel && hready && htrans[1];
		s_nxt.dp_write = hwrite;
		s_nxt.dp_addr = haddr[11:0];
		s_nxt.hrdata = 32'h0;
		if (hsel && hready && htrans[1] && !hwrite) begin
			unique case (haddr[11:0])
				`FPC_OFF_ADDR:   s_nxt.hrdata = {6'h0, s_r.addr};
				`FPC_OFF_CMD:    s_nxt.hrdata = {28'h0, s_r.op};
				`FPC_OFF_STATUS: s_nxt.hrdata = {26'h0, s_r.mode, 1'b0, s_r.err,
					s_r.done, s_r.busy};
				`FPC_OFF_RDATA:  s_nxt.hrdata = {16'h0, s_r.rdata};
				default:         s_nxt.hrdata = 32'h0;
			endcase
		end
		// Flash bus cycle sequencer
		unique case (s_r.phase)
			fpc_pkg::FPC_PH_IDLE: begin
				s_nxt.pins.ce_n = 1'b1;
				s_nxt.pins.oe_n = 1'b1;
				s_nxt.pins.we_n = 1'b1;
				s_nxt.pins.dq_oe = 1'b0;
			end
			fpc_pkg::FPC_PH_SETUP: begin
				// Writes for commands, reads for array, status and overlay reads
				s_nxt.pins.addr = cyc.addr;
				// Upper byte zero on command writes
				s_nxt.pins.dq_out = cyc.data;
				s_nxt.pins.dq_oe = !cyc.is_read;
				s_nxt.pins.ce_n = 1'b0;
				// Run to zero: pins land a cycle late, select must lead by full setup
				if (s_r.cnt == 4'h0) begin
					s_nxt.phase = fpc_pkg::FPC_PH_STROBE;
					s_nxt.cnt = cyc.is_read ? 4'(`FPC_N_RD) : 4'(`FPC_N_WE);
					s_nxt.pins.oe_n = !cyc.is_read;
					s_nxt.pins.we_n = cyc.is_read;
				end else
					s_nxt.cnt = s_r.cnt - 4'h1;
			end
			fpc_pkg::FPC_PH_STROBE: begin
				if (s_r.cnt <= 4'h1) begin
					// Read value kept whole, bit 0 is status
					if (cyc.is_read)
						s_nxt.rdata = dq_sync_r;
					s_nxt.pins.oe_n = 1'b1;
					s_nxt.pins.we_n = 1'b1;
					s_nxt.phase = fpc_pkg::FPC_PH_RECOVER;
					s_nxt.cnt = 4'(`FPC_N_REC);
				end else
					s_nxt.cnt = s_r.cnt - 4'h1;
			end
			fpc_pkg::FPC_PH_RECOVER: begin
				s_nxt.pins.ce_n = 1'b1;
				s_nxt.pins.dq_oe = 1'b0;
				if (s_r.cnt > 4'h1)
					s_nxt.cnt = s_r.cnt - 4'h1;
				else if (s_r.step + 3'h1 < s_r.nsteps) begin
					s_nxt.step = s_r.step + 3'h1;
					s_nxt.phase = fpc_pkg::FPC_PH_SETUP;
					s_nxt.cnt = 4'(`FPC_N_SETUP);
				end else begin
					// Done set wins over a same-cycle clear
					s_nxt.phase = fpc_pkg::FPC_PH_IDLE;
					s_nxt.busy = 1'b0;
					s_nxt.done = 1'b1;
					s_nxt.mode = op_mode(s_r.op, s_r.mode);
				end
			end
			default: s_nxt.phase = fpc_pkg::FPC_PH_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
			s_r.pins.ce_n <= 1'b1;
			s_r.pins.oe_n <= 1'b1;
			s_r.pins.we_n <= 1'b1;
			s_r.hready <= 1'b1;
		end else
			s_r <= s_nxt;
	end

	// Outputs straight from the state flops, except hresp tied low
	assign hreadyout    = s_r.hready;
	assign hresp        = 1'b0;
	assign hrdata       = s_r.hrdata;
	assign flash_addr   = s_r.pins.addr[AW-1:0];
	assign flash_dq_out = s_r.pins.dq_out;
	assign flash_dq_oe  = s_r.pins.dq_oe;
	assign flash_ce_n   = s_r.pins.ce_n;
	assign flash_oe_n   = s_r.pins.oe_n;
	assign flash_we_n   = s_r.pins.we_n;

endmodule // fpc_ctrl

// [pkg/fpc_defines.svh]
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH

// Register byte offsets on the AHB-Lite slave
`define FPC_OFF_CMD      12'h000
`define FPC_OFF_ADDR     12'h004
`define FPC_OFF_DATA     12'h008
`define FPC_OFF_STATUS   12'h00c
`define FPC_OFF_RDATA    12'h010

// Command register fields
`define FPC_CMD_OP_LSB   0
`define FPC_CMD_OP_W     4

// Status register fields
`define FPC_ST_BUSY      0
`define FPC_ST_DONE      1
`define FPC_ST_ERR       2
`define FPC_ST_MODE_LSB  4

// Command codes written on the flash data pins
`define FPC_UNLOCK1_ADDR 16'h0555
`define FPC_UNLOCK2_ADDR 16'h02aa
`define FPC_UNLOCK1_DATA 16'h00aa
`define FPC_UNLOCK2_DATA 16'h0055
`define FPC_CODE_FREEZE  16'h0050
`define FPC_CODE_DYN     16'h00e0
`define FPC_CODE_ECC     16'h0075
`define FPC_CODE_PROG    16'h00a0
`define FPC_CODE_EXIT1   16'h0090
`define FPC_CODE_RESET   16'h00f0
`define FPC_CODE_ZERO    16'h0000
`define FPC_CODE_ONE     16'h0001

// Sector select starts at this address bit
`define FPC_SECTOR_LSB   16

// Bus-cycle timing in ns and derived clock counts at 10 ns
`define FPC_CLK_NS       10
`define FPC_T_SETUP_NS   30
`define FPC_T_WE_NS      50
`define FPC_T_RD_NS      110
`define FPC_T_REC_NS     20
`define FPC_N_SETUP ((`FPC_T_SETUP_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_N_WE    ((`FPC_T_WE_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_N_RD    ((`FPC_T_RD_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_N_REC   ((`FPC_T_REC_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)

`endif

// [pkg/fpc_pkg.sv]
package fpc_pkg;

	// High-level operations software can order
	typedef enum logic [3:0] {
		FPC_OP_ARRAY_READ,
		FPC_OP_FREEZE_ENTER,
		FPC_OP_FREEZE_CLEAR,
		FPC_OP_FREEZE_READ,
		FPC_OP_DYN_ENTER,
		FPC_OP_DYN_SET,
		FPC_OP_DYN_CLEAR,
		FPC_OP_DYN_READ,
		FPC_OP_ECC_ENTER,
		FPC_OP_ECC_READ,
		FPC_OP_SET_EXIT,
		FPC_OP_RESET_EXIT
	} fpc_op_e;

	// Overlay the flash is believed to be in
	typedef enum logic [1:0] {
		FPC_MODE_ARRAY,
		FPC_MODE_FREEZE,
		FPC_MODE_DYN,
		FPC_MODE_ECC
	} fpc_mode_e;

	// Bus cycle sequencer phases
	typedef enum logic [2:0] {
		FPC_PH_IDLE,
		FPC_PH_SETUP,
		FPC_PH_STROBE,
		FPC_PH_RECOVER
	} fpc_phase_e;

	// Flash pin bundle
	typedef struct packed {
		logic [25:0] addr;
		logic [15:0] dq_out;
		logic        dq_oe;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
	} fpc_pins_s;

	// One flash bus cycle
	typedef struct packed {
		logic        is_read;
		logic [25:0] addr;
		logic [15:0] data;
	} fpc_cycle_s;

	// Whole controller state
	typedef struct packed {
		fpc_pins_s   pins;
		fpc_phase_e  phase;
		logic [3:0]  cnt;
		logic [2:0]  step;
		logic [2:0]  nsteps;
		fpc_op_e     op;
		fpc_mode_e   mode;
		logic [25:0] addr;
		logic        busy;
		logic        done;
		logic        err;
		logic [15:0] rdata;
		logic        hready;
		logic [31:0] hrdata;
		logic        dp_valid;
		logic        dp_write;
		logic [11:0] dp_addr;
	} fpc_state_s;

endpackage

// [test/fpc_ctrl_checker.sv]
`timescale 1ns/10ps
module fpc_ctrl_checker #(
	parameter int AW = 26
) (
	// Clock and reset
	input wire logic          hclk,
	input wire logic          hresetn,
	// Flash pins
	input wire logic [AW-1:0] flash_addr,
	input wire logic [15:0]   flash_dq_out,
	input wire logic          flash_dq_oe,
	input wire logic          flash_ce_n,
	input wire logic          flash_oe_n,
	input wire logic          flash_we_n
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Strobe shape and bus ownership on each flash cycle
	a_strobe_excl: assert property (flash_we_n || flash_oe_n)
		else $error("write and read strobes low together");
	a_strobe_sel: assert property (!(flash_we_n && flash_oe_n) |-> !flash_ce_n)
		else $error("strobe without chip select");
	a_we_width: assert property ($fell(flash_we_n) |-> (!flash_we_n)[*5] ##1 flash_we_n)
		else $error("write strobe not five cycles");
	a_oe_width: assert property ($fell(flash_oe_n) |->
		(!flash_oe_n)[*8] ##1 (!flash_oe_n)[*3] ##1 flash_oe_n)
		else $error("read strobe not eleven cycles");
	a_setup_gap: assert property ($fell(flash_ce_n) |->
		(flash_we_n && flash_oe_n)[*3] ##1 !(flash_we_n && flash_oe_n))
		else $error("setup before strobe not three cycles");
	a_write_drive: assert property (!flash_we_n |-> flash_dq_oe)
		else $error("write strobe with data not driven");
	a_read_float: assert property (!flash_oe_n |-> !flash_dq_oe)
		else $error("data driven during read");
	a_upper_zero: assert property (flash_dq_oe |-> flash_dq_out[15:8] == 8'h00)
		else $error("upper data byte not zero");
	a_unlock_addr: assert property (!flash_we_n && flash_dq_out inside {16'h00aa, 16'h0055}
		|-> flash_addr[AW-1:11] == '0)
		else $error("unlock cycle with high address bits set");
	a_addr_hold: assert property (!flash_ce_n && $past(!flash_ce_n)
		|-> $stable(flash_addr) && $stable(flash_dq_out))
		else $error("address or data moved within a cycle");
	a_exit_pair: assert property ($fell(flash_we_n) && flash_dq_out == 16'h0090
		|-> ##[1:30] ($fell(flash_we_n) && flash_dq_out == 16'h0000))
		else $error("exit code not followed by zero");
	// Main entry sequences seen
	c_freeze: cover property ($fell(flash_we_n) && flash_dq_out == 16'h0050);
	c_dyn: cover property ($fell(flash_we_n) && flash_dq_out == 16'h00e0);
	c_ecc: cover property ($fell(flash_we_n) && flash_dq_out == 16'h0075);
endmodule // fpc_ctrl_checker

bind fpc_ctrl fpc_ctrl_checker #(.AW(AW)) chk_u (.hclk(hclk), .hresetn(hresetn),
	.flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
	.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));

// [test/fpc_flash_model.sv]
`timescale 1ns/10ps
module fpc_flash_model (
	// Pins from the controller
	input wire logic [25:0] addr,
	input wire logic [15:0] dq_out,
	input wire logic        ce_n,
	input wire logic        oe_n,
	input wire logic        we_n,
	// Read data back
	output logic     [15:0] dq_in
);
	logic [1:0]    mode;
	logic [1:0]    ulk;
	logic          prog;
	logic          ext;
	logic          frz;
	logic [1023:0] dyn;
	logic [15:0]   val;
	logic [15:0]   last;
	initial begin
		{mode, ulk, prog, ext, last} = '0;
		frz = 1'b1;
		dyn = '1;
	end
	// decode on low byte and low address
	always @(posedge we_n) if (ce_n === 1'b0) begin
		if (dq_out[7:0] == 8'hf0) {mode, ulk, prog, ext} = '0;
		else if (prog) begin
			prog = 1'b0;
			if (mode == 2'd2) dyn[addr[25:16]] = dq_out[0];
			else if (mode == 2'd1 && !dq_out[0]) frz = 1'b0;
		end else if (ext) begin
			ext = 1'b0;
			if (dq_out[7:0] == 8'h00) mode = 2'd0;
		end else if (mode != 2'd0 && dq_out[7:0] == 8'ha0) prog = 1'b1;
		else if (mode != 2'd0 && dq_out[7:0] == 8'h90) ext = 1'b1;
		else if (ulk == 2'd0 && addr[10:0] == 11'h555 && dq_out[7:0] == 8'haa) ulk = 2'd1;
		else if (ulk == 2'd1 && addr[10:0] == 11'h2aa && dq_out[7:0] == 8'h55) ulk = 2'd2;
		else if (ulk == 2'd2 && addr[10:0] == 11'h555) begin
			ulk = 2'd0;
			case (dq_out[7:0])
				8'h50: mode = 2'd1;
				8'he0: mode = 2'd2;
				8'h75: mode = 2'd3;
				default: mode = mode;
			endcase
		end else ulk = 2'd0;
	end
	// overlay picks what a read returns
	always_comb begin
		case (mode)
			2'd1: val = {15'h0000, frz};
			2'd2: val = {15'h0000, dyn[addr[25:16]]};
			2'd3: val = {15'h0000, ^addr[15:0]};
			default: val = addr[15:0] ^ 16'h3c3c;
		endcase
	end
	// Released bus shows the inverse, so stale data never matches by luck
	always @(val or ce_n or oe_n) if (!ce_n && !oe_n) last = val;
	assign dq_in = (!ce_n && !oe_n) ? val : ~last;
endmodule // fpc_flash_model

// [test/testbench.sv]
`timescale 1ns/10ps
`include "fpc_defines.svh"
module testbench;
	logic               hclk;
	logic               hresetn;
	logic               hsel;
	logic [31:0]        haddr;
	logic [1:0]         htrans;
	logic               hwrite;
	logic [2:0]         hsize;
	logic [31:0]        hwdata;
	logic               hreadyout;
	logic               hresp;
	logic [31:0]        hrdata;
	fpc_pkg::fpc_pins_s pins;
	logic [15:0]        dq_in;
	logic               want;
	logic               dph;
	logic [31:0]        exp_q[$];
	logic [31:0]        rd;
	logic [25:0]        a;
	int                 failures;
	int                 n_compared;
	fpc_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flash_addr(pins.addr),
		.flash_dq_out(pins.dq_out), .flash_dq_oe(pins.dq_oe), .flash_dq_in(dq_in),
		.flash_ce_n(pins.ce_n), .flash_oe_n(pins.oe_n), .flash_we_n(pins.we_n));
	fpc_flash_model flash_u (.addr(pins.addr), .dq_out(pins.dq_out), .ce_n(pins.ce_n),
		.oe_n(pins.oe_n), .we_n(pins.we_n), .dq_in(dq_in));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		n_compared++;
		if (seen !== expd) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
		end
	endtask
	task automatic report_and_stop();
		$display("compared=%0d mismatches=%0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Bounded wait for ready, looked at mid-cycle so the edge sees the same
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(negedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (n >= 100) begin
			failures++;
			report_and_stop();
		end
	endtask
	task automatic ahb(input logic wr, input logic [11:0] off, input logic [31:0] wd);
		htrans <= 2'h2;
		haddr <= {20'h00000, off};
		hwrite <= wr;
		wait_rdy();
		@(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		@(posedge hclk);
	endtask
	task automatic expect_rd(input logic [11:0] off, input logic [31:0] e);
		exp_q.push_back(e);
		want <= 1'b1;
		ahb(1'b0, off, 32'h0);
		want <= 1'b0;
	endtask
	// Order one operation, poll until finished, check status, clear flags
	task automatic run_op(input logic [3:0] op, input logic [25:0] fa,
		input logic [1:0] m, input logic e);
		int n;
		ahb(1'b1, `FPC_OFF_ADDR, {6'h00, fa});
		ahb(1'b1, `FPC_OFF_CMD, {28'h0, op});
		n = 0;
		do begin
			ahb(1'b0, `FPC_OFF_STATUS, 32'h0);
			n++;
		end while ((rd[0] !== 1'b0 || rd[2:1] == 2'b00) && n < 200);
		if (n >= 200) begin
			failures++;
			report_and_stop();
		end
		expect_rd(`FPC_OFF_STATUS, {26'h0, m, 1'b0, e, !e, 1'b0});
		ahb(1'b1, `FPC_OFF_STATUS, 32'h6);
	endtask
	// Monitor: a checked read's data phase takes the oldest note
	always @(posedge hclk) dph <= htrans[1] && hsel && hreadyout && !hwrite && want;
	always @(negedge hclk) if (dph === 1'b1 && hreadyout === 1'b1) begin
		check(hrdata, exp_q.pop_front());
		check({31'h0, hresp}, 32'h0);
	end
	initial begin
		{hresetn, hwrite, want, haddr, htrans, hwdata} = '0;
		hsel = 1'b1;
		hsize = 3'h2;
		failures = 0;
		n_compared = 0;
		void'($urandom(11690));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 4; i++) begin
			a = 26'($urandom());
			run_op(4'd0, a, 2'd0, 1'b0);
			expect_rd(`FPC_OFF_RDATA, {16'h0000, a[15:0] ^ 16'h3c3c});
		end
		$display("test array_read done");
		// freeze lock clear then exit pair
		run_op(4'd1, 26'h0, 2'd1, 1'b0);
		run_op(4'd3, a, 2'd1, 1'b0);
		expect_rd(`FPC_OFF_RDATA, 32'h1);
		run_op(4'd2, a, 2'd1, 1'b0);
		run_op(4'd3, 26'h0, 2'd1, 1'b0);
		expect_rd(`FPC_OFF_RDATA, 32'h0);
		run_op(4'd10, 26'h0, 2'd0, 1'b0);
		$display("test freeze done");
		// sector bits follow the high address bits
		run_op(4'd4, 26'h0, 2'd2, 1'b0);
		for (int i = 0; i < 3; i++) begin
			a = 26'($urandom());
			run_op(4'd5, a, 2'd2, 1'b0);
			run_op(4'd7, a ^ 26'h00ffff, 2'd2, 1'b0);
			expect_rd(`FPC_OFF_RDATA, 32'h0);
			run_op(4'd7, a ^ 26'h010000, 2'd2, 1'b0);
			expect_rd(`FPC_OFF_RDATA, 32'h1);
			run_op(4'd6, a, 2'd2, 1'b0);
			run_op(4'd7, a, 2'd2, 1'b0);
			expect_rd(`FPC_OFF_RDATA, 32'h1);
		end
		run_op(4'd11, 26'h0, 2'd0, 1'b0);
		$display("test dynamic done");
		// status overlay, then back in array mode
		run_op(4'd8, 26'h0, 2'd3, 1'b0);
		a = 26'($urandom());
		run_op(4'd9, a, 2'd3, 1'b0);
		expect_rd(`FPC_OFF_RDATA, {31'h0, ^a[15:0]});
		run_op(4'd11, 26'h0, 2'd0, 1'b0);
		run_op(4'd0, a, 2'd0, 1'b0);
		expect_rd(`FPC_OFF_RDATA, {16'h0000, a[15:0] ^ 16'h3c3c});
		expect_rd(`FPC_OFF_ADDR, {6'h00, a});
		expect_rd(`FPC_OFF_CMD, 32'h0);
		$display("test ecc done");
		// Refused order and an unknown order code
		run_op(4'd5, a, 2'd0, 1'b1);
		run_op(4'd12, a, 2'd0, 1'b1);
		// Order during a running entry is refused, the entry still finishes
		ahb(1'b1, `FPC_OFF_CMD, 32'h8);
		ahb(1'b1, `FPC_OFF_CMD, 32'hb);
		expect_rd(`FPC_OFF_STATUS, 32'h5);
		repeat (80) @(posedge hclk);
		expect_rd(`FPC_OFF_STATUS, 32'h36);
		ahb(1'b1, `FPC_OFF_STATUS, 32'h6);
		run_op(4'd11, 26'h0, 2'd0, 1'b0);
		ahb(1'b1, 12'h014, 32'hffff_ffff);
		expect_rd(12'h014, 32'h0);
		$display("test refusal done");
		report_and_stop();
	end
endmodule // testbench
